/* pfsm_port_f_signal_mux.v */
`include "pfsm_map.vh"
// Summary of operation
// - After reset all lines are GPIO inputs with pull-up, no alternate.
// - Serial clock line drives out as master, is the clock input as slave.
// - Return-data line is input as master, device output as slave.
// - Slave return-data output floats whenever the line 7 pad reads high, whether or not line 7 is routed as slave select.
// - Forward-data line drives out as master, is sampled in slave mode.
// - External master asserts low slave select to address the device.
// - Buffered clock out uses source picked by clock-output select field.
// - Transmit line is output, or shared transmit/receive in single-wire mode.
// - Asserted fault inputs 6 and 7 disable PWM outputs 6 and 7.
// - Auxiliary PWM lines drive outputs or feed input capture.
module pfsm_port_f_signal_mux (
	input  wire                         i_ref_clk,       // 20 MHz clock.
	input  wire                         i_rst_n,         // Async reset.
	input  wire [`PFSM_LINES*`PFSM_SEL_W-1:0] i_line_sel, // Per-line select.
	input  wire                         i_spi_master,    // Serial is master.
	input  wire                         i_sci_single,    // Single-wire mode.
	input  wire [1:0]                   i_aux_capture,   // Aux lines capture.
	input  wire [`PFSM_CKO_W-1:0]       i_clock_out_source_select, // Field.
	input  wire [3:0]                   i_clk_sources,   // Clock candidates.
	input  wire                         i_external_clock_select, // Osc bit.
	input  wire [`PFSM_LINES-1:0]       i_pad_in,        // Pad levels.
	input  wire [`PFSM_LINES-1:0]       i_gpio_out,      // GPIO data.
	input  wire [`PFSM_LINES-1:0]       i_gpio_dir,      // GPIO 1 = out.
	input  wire                         i_spi_sclk_out,  // Master clock.
	input  wire                         i_spi_fwd_out,   // Master data.
	input  wire                         i_spi_ret_out,   // Slave data.
	input  wire                         i_spi_ss_n_out,  // Master select.
	input  wire                         i_sci_tx,        // Transmit data.
	input  wire                         i_sci_tx_oe,     // Single-wire drive.
	input  wire [1:0]                   i_pwm_aux_out,   // Aux outputs.
	input  wire [1:0]                   i_pwm_out_67,    // PWM outputs 6,7.
	input  wire [3:0]                   i_xbar_out,      // Crossbar out 6..9.
	input  wire                         i_scl_low,       // Bus clock pull.
	input  wire                         i_cmp_d,         // Comparator D.
	output reg  [`PFSM_LINES-1:0]       o_pad_out,       // Pad data.
	output reg  [`PFSM_LINES-1:0]       o_pad_oe,        // Pad drive.
	output reg  [`PFSM_LINES-1:0]       o_pad_pullup,    // Pull-up enable.
	output reg  [`PFSM_LINES-1:0]       o_gpio_in,       // GPIO read.
	output reg                          o_spi_sclk_in,   // Slave clock in.
	output reg                          o_spi_ret_in,    // Master data in.
	output reg                          o_spi_fwd_in,    // Slave data in.
	output reg                          o_spi_ss_n_in,   // Slave select in.
	output reg                          o_sci_rx,        // Receive data.
	output reg  [1:0]                   o_pwm_capture,   // Capture inputs.
	output reg  [1:0]                   o_pwm_fault,     // Fault 6,7 seen.
	output reg  [1:0]                   o_pwm_67_gated,  // Gated PWM 6,7.
	output reg  [1:0]                   o_xbar_in,       // Crossbar in 6,7.
	output reg                          o_scl_in,        // Bus clock in.
	output wire                         o_ext_clk_in,    // Ext clock used.
	output wire                         o_buffered_clock_out // Clock out.
);
	// ============================================================
	// Selection state.
	wire [`PFSM_LINES*`PFSM_SEL_W-1:0] sel;
	pfsm_sel_reg #(
		.LINES (`PFSM_LINES)
	) u_sel (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_sel     (i_line_sel),
		.o_sel     (sel)
	);

	function [`PFSM_SEL_W-1:0] fsel;
		input [`PFSM_LINES*`PFSM_SEL_W-1:0] s;
		input integer l;
		begin
			fsel = s[l*`PFSM_SEL_W +: `PFSM_SEL_W];
		end
	endfunction

	// ============================================================
	// Clock output.
	wire ck_out;
	pfsm_clk_out u_cko (
		.i_ref_clk (i_ref_clk),
		.i_rst_n   (i_rst_n),
		.i_src_sel (i_clock_out_source_select),
		.i_sources (i_clk_sources),
		.o_clk     (ck_out)
	);
	// The clock output stays combinational so the divided source is not
	// resampled by the 20 MHz clock and keeps its own edges.
	assign o_buffered_clock_out = (fsel(sel, `PFSM_L_CLKO) ==
		`PFSM_SEL_ALT1) ? ck_out : 1'b0;
	// The external clock is only taken when both select bits agree;
	// powering down the oscillator is left to software.
	assign o_ext_clk_in = (fsel(sel, `PFSM_L_SCLK) == `PFSM_SEL_ALT1) &&
		i_external_clock_select;

	// ============================================================
	// Registered input path.
	reg [`PFSM_LINES-1:0] pad_reg;
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pad_reg <= {`PFSM_LINES{1'b1}};
		end else begin
			pad_reg <= i_pad_in;
		end
	end

	// ============================================================
	// Pad driver mux.
	integer n;
	reg [`PFSM_SEL_W-1:0] s;
	always @* begin
		s = 4'h0;
		o_pad_out = {`PFSM_LINES{1'b0}};
		o_pad_oe = {`PFSM_LINES{1'b0}};
		o_pad_pullup = {`PFSM_LINES{1'b0}};
		for (n = 0; n < `PFSM_LINES; n = n + 1) begin
			s = fsel(sel, n);
			if (s == `PFSM_SEL_GPIO) begin
				o_pad_out[n] = i_gpio_out[n];
				o_pad_oe[n] = i_gpio_dir[n];
				o_pad_pullup[n] = ~i_gpio_dir[n];
			end
		end
		// Line 0: crossbar in 6, serial clock.
		if (fsel(sel, 0) == `PFSM_SEL_ALT2) begin
			o_pad_out[0] = i_spi_sclk_out;
			o_pad_oe[0] = i_spi_master;
		end
		// Line 1: clock out, crossbar in 7, comparator D.
		if (fsel(sel, 1) == `PFSM_SEL_ALT1) begin
			o_pad_out[1] = ck_out;
			o_pad_oe[1] = 1'b1;
		end else if (fsel(sel, 1) == `PFSM_SEL_ALT3) begin
			o_pad_out[1] = i_cmp_d;
			o_pad_oe[1] = 1'b1;
		end
		// Line 2: bus clock open drain, crossbar out 6, return data.
		if (fsel(sel, 2) == `PFSM_SEL_ALT1) begin
			o_pad_out[2] = 1'b0;
			o_pad_oe[2] = i_scl_low;
		end else if (fsel(sel, 2) == `PFSM_SEL_ALT2) begin
			o_pad_out[2] = i_xbar_out[0];
			o_pad_oe[2] = 1'b1;
		end else if (fsel(sel, 2) == `PFSM_SEL_ALT3) begin
			o_pad_out[2] = i_spi_ret_out;
			// Drive only as a slave with the line 7 pad low, routed or not; float otherwise.
			o_pad_oe[2] = ~i_spi_master & ~pad_reg[`PFSM_L_SSEL];
		end
		// Line 3: crossbar out 7, forward data.
		if (fsel(sel, 3) == `PFSM_SEL_ALT2) begin
			o_pad_out[3] = i_xbar_out[1];
			o_pad_oe[3] = 1'b1;
		end else if (fsel(sel, 3) == `PFSM_SEL_ALT3) begin
			o_pad_out[3] = i_spi_fwd_out;
			o_pad_oe[3] = i_spi_master;
		end
		// Line 4: transmit, crossbar out 8, aux channel 0 / fault 6.
		if (fsel(sel, 4) == `PFSM_SEL_ALT1) begin
			o_pad_out[4] = i_sci_tx;
			o_pad_oe[4] = i_sci_single ? i_sci_tx_oe : 1'b1;
		end else if (fsel(sel, 4) == `PFSM_SEL_ALT2) begin
			o_pad_out[4] = i_xbar_out[2];
			o_pad_oe[4] = 1'b1;
		end else if (fsel(sel, 4) == `PFSM_SEL_ALT3) begin
			o_pad_out[4] = i_pwm_aux_out[0];
			o_pad_oe[4] = ~i_aux_capture[0];
		end
		// Line 5: receive, crossbar out 9, aux channel 1 / fault 7.
		if (fsel(sel, 5) == `PFSM_SEL_ALT2) begin
			o_pad_out[5] = i_xbar_out[3];
			o_pad_oe[5] = 1'b1;
		end else if (fsel(sel, 5) == `PFSM_SEL_ALT3) begin
			o_pad_out[5] = i_pwm_aux_out[1];
			o_pad_oe[5] = ~i_aux_capture[1];
		end
		// Line 7: slave select, driven by the device only as master.
		if (fsel(sel, 7) == `PFSM_SEL_ALT2) begin
			o_pad_out[7] = i_spi_ss_n_out;
			o_pad_oe[7] = i_spi_master;
		end
	end

	// ============================================================
	// Registered inputs to peripherals.
	// Fault lines are the fourth function of lines 4 and 5 when the aux
	// channel is set for capture; faults share the capture select there.
	wire f6 = (fsel(sel, 4) == `PFSM_SEL_ALT3) && i_aux_capture[0] &&
		pad_reg[4];
	wire f7 = (fsel(sel, 5) == `PFSM_SEL_ALT3) && i_aux_capture[1] &&
		pad_reg[5];
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_gpio_in <= {`PFSM_LINES{1'b1}};
			o_spi_sclk_in <= 1'b0;
			o_spi_ret_in <= 1'b0;
			o_spi_fwd_in <= 1'b0;
			o_spi_ss_n_in <= 1'b1;
			o_sci_rx <= 1'b1;
			o_pwm_capture <= 2'h0;
			o_pwm_fault <= 2'h0;
			o_pwm_67_gated <= 2'h0;
			o_xbar_in <= 2'h0;
			o_scl_in <= 1'b1;
		end else begin
			o_gpio_in <= pad_reg;
			o_spi_sclk_in <= (fsel(sel, 0) == `PFSM_SEL_ALT2) &&
				!i_spi_master && pad_reg[0];
			o_spi_ret_in <= (fsel(sel, 2) == `PFSM_SEL_ALT3) &&
				i_spi_master && pad_reg[2];
			o_spi_fwd_in <= (fsel(sel, 3) == `PFSM_SEL_ALT3) &&
				!i_spi_master && pad_reg[3];
			// Unrouted select reads as not asserted.
			o_spi_ss_n_in <= !((fsel(sel, 7) == `PFSM_SEL_ALT2) &&
				!i_spi_master && !pad_reg[7]);
			if (fsel(sel, 5) == `PFSM_SEL_ALT1) begin
				o_sci_rx <= pad_reg[5];
			end else if (fsel(sel, 4) == `PFSM_SEL_ALT1 && i_sci_single) begin
				o_sci_rx <= pad_reg[4];
			end else begin
				o_sci_rx <= 1'b1;
			end
			o_pwm_capture <= {pad_reg[5] & (fsel(sel, 5) == `PFSM_SEL_ALT3),
				pad_reg[4] & (fsel(sel, 4) == `PFSM_SEL_ALT3)};
			o_pwm_fault <= {f7, f6};
			o_pwm_67_gated <= i_pwm_out_67 & ~{f7, f6};
			o_xbar_in <= {pad_reg[1] & (fsel(sel, 1) == `PFSM_SEL_ALT2),
				pad_reg[0] & (fsel(sel, 0) == `PFSM_SEL_ALT1)};
			o_scl_in <= (fsel(sel, 2) == `PFSM_SEL_ALT1) ? pad_reg[2] : 1'b1;
		end
	end
endmodule

/* pfsm_map.vh */
`ifndef PFSM_MAP_VH
`define PFSM_MAP_VH
// ============================================================
// Function select codes, one-hot per line.
`define PFSM_SEL_W        4
`define PFSM_SEL_GPIO     4'h1
`define PFSM_SEL_ALT1     4'h2
`define PFSM_SEL_ALT2     4'h4
`define PFSM_SEL_ALT3     4'h8
`define PFSM_SEL_RESET    4'h1
// ============================================================
// Line indices of the nine-line port.
`define PFSM_LINES        9
`define PFSM_L_SCLK       0
`define PFSM_L_CLKO       1
`define PFSM_L_SCL        2
`define PFSM_L_RET        2
`define PFSM_L_FWD        3
`define PFSM_L_TX         4
`define PFSM_L_RX         5
`define PFSM_L_AUX3       6
`define PFSM_L_SSEL       7
`define PFSM_L_RX0        8
// ============================================================
// Clock output source codes.
`define PFSM_CKO_W        2
`define PFSM_CKO_RESET    2'h0
`endif

/* pfsm_sel_reg.v */
`include "pfsm_map.vh"
// ============================================================
// Per-line selection holder; illegal codes fall back to GPIO.
module pfsm_sel_reg #(
	parameter LINES = `PFSM_LINES
) (
	input  wire                        i_ref_clk, // Clock.
	input  wire                        i_rst_n,   // Async reset.
	input  wire [LINES*`PFSM_SEL_W-1:0] i_sel,    // Requested selects.
	output reg  [LINES*`PFSM_SEL_W-1:0] o_sel     // Legal one-hot selects.
);
	function onehot;
		input [`PFSM_SEL_W-1:0] v;
		begin
			onehot = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
		end
	endfunction

	reg [LINES*`PFSM_SEL_W-1:0] sel_next;
	integer k;
	always @* begin
		sel_next = {LINES*`PFSM_SEL_W{1'b0}};
		for (k = 0; k < LINES; k = k + 1) begin
			if (onehot(i_sel[k*`PFSM_SEL_W +: `PFSM_SEL_W])) begin
				sel_next[k*`PFSM_SEL_W +: `PFSM_SEL_W] =
					i_sel[k*`PFSM_SEL_W +: `PFSM_SEL_W];
			end else begin
				sel_next[k*`PFSM_SEL_W +: `PFSM_SEL_W] = `PFSM_SEL_GPIO;
			end
		end
	end

	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sel <= {LINES{`PFSM_SEL_RESET}};
		end else begin
			o_sel <= sel_next;
		end
	end
endmodule

/* pfsm_clk_out.v */
`include "pfsm_map.vh"
// ============================================================
// Buffered clock output source chooser.
module pfsm_clk_out (
	input  wire                   i_ref_clk,  // Clock.
	input  wire                   i_rst_n,    // Async reset.
	input  wire [`PFSM_CKO_W-1:0] i_src_sel,  // Source select field.
	input  wire [3:0]             i_sources,  // Candidate clocks.
	output reg                    o_clk       // Chosen clock.
);
	reg [`PFSM_CKO_W-1:0] sel_reg;
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sel_reg <= `PFSM_CKO_RESET;
		end else begin
			sel_reg <= i_src_sel;
		end
	end
	always @* begin
		o_clk = i_sources[sel_reg];
	end
endmodule

/* pfsm_mux_assertions.sv */
module pfsm_mux_checker (
	input wire logic        i_ref_clk,                 // Clock.
	input wire logic        i_rst_n,                   // Reset.
	input wire logic [35:0] i_line_sel,                // Selects.
	input wire logic        i_spi_master,              // Master.
	input wire logic        i_sci_single,              // One wire.
	input wire logic [1:0]  i_aux_capture,             // Capture.
	input wire logic [1:0]  i_clock_out_source_select, // Source.
	input wire logic [3:0]  i_clk_sources,             // Clocks.
	input wire logic        i_sci_tx_oe,               // Tx drive.
	input wire logic [8:0]  i_pad_in,                  // Pads.
	input wire logic [8:0]  i_gpio_dir,                // Direction.
	input wire logic        i_spi_sclk_out,            // Clock out.
	input wire logic [8:0]  o_pad_out,                 // Pad level.
	input wire logic [8:0]  o_pad_oe,                  // Pad drive.
	input wire logic [8:0]  o_pad_pullup,              // Pull-up.
	input wire logic [1:0]  o_pwm_fault,               // Faults.
	input wire logic [1:0]  o_pwm_67_gated,            // Gated.
	input wire logic        o_spi_ss_n_in,             // Select.
	input wire logic        o_buffered_clock_out       // Clock.
);
	logic [1:0] up;
	wire  [3:0] n0 = i_line_sel[3:0];
	wire  [3:0] n1 = i_line_sel[7:4];
	wire  [3:0] n2 = i_line_sel[11:8];
	wire  [3:0] n3 = i_line_sel[15:12];
	wire  [3:0] n4 = i_line_sel[19:16];
	wire  [3:0] n5 = i_line_sel[23:20];
	wire  [3:0] n7 = i_line_sel[31:28];
	// ============================================================
	// History depth since reset, so that $past never sees reset values.
	always @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			up <= 2'h0;
		else
			up <= {up[0], 1'b1};
	end
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// ============================================================
	// Properties.
	property p_rst;
		$rose(i_rst_n) |-> o_pad_oe == i_gpio_dir && o_pad_pullup == ~i_gpio_dir;
	endproperty
	property p_sclk;
		up[0] && $past(n0) == 4'h4 |-> o_pad_oe[0] == i_spi_master
			&& (!i_spi_master || o_pad_out[0] == i_spi_sclk_out);
	endproperty
	property p_ret;
		up[0] && $past(n2) == 4'h8
			|-> o_pad_oe[2] == (!i_spi_master && !$past(i_pad_in[7]));
	endproperty
	property p_fwd;
		up[0] && $past(n3) == 4'h8 |-> o_pad_oe[3] == i_spi_master;
	endproperty
	property p_clko;
		up[0] && $past(n1) == 4'h2 |-> o_buffered_clock_out
			== i_clk_sources[$past(i_clock_out_source_select)];
	endproperty
	property p_tx;
		up[0] && $past(n4) == 4'h2 |-> o_pad_oe[4] == (!i_sci_single || i_sci_tx_oe);
	endproperty
	property p_fault;
		up[1] && $past(n4, 2) == 4'h8 && $past(i_pad_in[4], 2)
			&& $past(i_aux_capture[0]) && $past(i_aux_capture[0], 2)
			|-> o_pwm_fault[0] ##0 !o_pwm_67_gated[0];
	endproperty
	property p_ss;
		up[1] && $past(n7, 2) == 4'h4 && !$past(i_pad_in[7], 2)
			&& !$past(i_spi_master) |-> !o_spi_ss_n_in;
	endproperty
	property p_aux;
		up[0] && $past(n5) == 4'h8 |-> o_pad_oe[5] == !i_aux_capture[1];
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	a_sclk: assert property (p_sclk) else $error("sclk dir wrong");
	a_ret: assert property (p_ret) else $error("ret drive wrong");
	a_fwd: assert property (p_fwd) else $error("fwd dir wrong");
	a_clko: assert property (p_clko) else $error("clock out wrong");
	a_tx: assert property (p_tx) else $error("tx drive wrong");
	a_fault: assert property (p_fault) else $error("fault gate wrong");
	a_ss: assert property (p_ss) else $error("select not seen");
	a_aux: assert property (p_aux) else $error("aux dir wrong");
	c_fault: cover property (o_pwm_fault[0]);
	c_ss: cover property (up[1] && !o_spi_ss_n_in);
	c_clk: cover property (o_buffered_clock_out);
endmodule

bind pfsm_port_f_signal_mux pfsm_mux_checker pfsm_mux_checker_inst (.*);

/* pfsm_far_side.sv */
module pfsm_far_side (
	input  wire logic       i_ref_clk, // Clock.
	input  wire logic [8:0] i_oe,      // Device drives.
	input  wire logic [8:0] i_out,     // Device level.
	input  wire logic [8:0] i_pu,      // Pull-up on.
	input  wire logic [8:0] i_drv,     // Far side drives.
	input  wire logic [8:0] i_val,     // Far side level.
	output logic      [8:0] o_pad      // Resolved pad.
);
	timeunit 1ns;
	timeprecision 1ns;
	logic tog = 1'b0;
	always @(posedge i_ref_clk)
		tog <= ~tog;
	// The far side yields where the device drives; a line left floating
	// wanders instead of keeping a convenient last value.
	always @* begin
		for (int n = 0; n < 9; n++)
			o_pad[n] = i_oe[n] ? i_out[n] : i_drv[n] ? i_val[n] : i_pu[n] | tog;
	end
endmodule

/* tb_port_f_signal_mux.sv */
module tb_port_f_signal_mux;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk = 0, rst_n = 0, master = 0, single = 0, exsel = 0;
	logic [35:0] sel = 36'h111111111;
	logic [1:0]  cap = 0, src = 0, flt, gat, capt;
	logic [7:0]  per = 0;
	logic [8:0]  val = 0, dir = 0, gout = 0, pad, oe, po, pu, eoe, eout;
	logic        ss, ext, bco;
	logic [8:0]  gin;
	logic        sckin, retin, fwdin, rx, sclin;
	logic [1:0]  xin;
	int          errors = 0, compares = 0, cyc = 0;
	logic [65:0] tbl [6] = '{
		{36'h111118814, 4'h8, 8'h03, 9'h009, 9'h009},
		{36'h111118814, 4'h0, 8'h04, 9'h004, 9'h004},
		{36'h111821411, 4'h0, 8'h58, 9'h034, 9'h034},
		{36'h111124121, 4'h4, 8'h60, 9'h00a, 9'h00a},
		{36'h111281211, 4'h0, 8'h21, 9'h014, 9'h010},
		{36'h111161113, 4'h0, 8'hff, 9'h000, 9'h000}};
	always #25 clk = ~clk;
	pfsm_port_f_signal_mux pfsm_port_f_signal_mux_inst (
		.i_ref_clk(clk), .i_rst_n(rst_n), .i_line_sel(sel),
		.i_spi_master(master), .i_sci_single(single), .i_aux_capture(cap),
		.i_clock_out_source_select(src), .i_clk_sources(per[7:4]),
		.i_external_clock_select(exsel), .i_pad_in(pad), .i_gpio_out(gout),
		.i_gpio_dir(dir), .i_spi_sclk_out(per[0]), .i_spi_fwd_out(per[1]),
		.i_spi_ret_out(per[2]), .i_spi_ss_n_out(per[2]), .i_sci_tx(per[3]),
		.i_sci_tx_oe(per[4]), .i_pwm_aux_out(per[6:5]),
		.i_pwm_out_67(per[1:0]), .i_xbar_out(per[7:4]), .i_scl_low(per[0]),
		.i_cmp_d(per[1]), .o_pad_out(po), .o_pad_oe(oe), .o_pad_pullup(pu),
		.o_gpio_in(gin), .o_spi_sclk_in(sckin), .o_spi_ret_in(retin),
		.o_spi_fwd_in(fwdin),
		.o_spi_ss_n_in(ss), .o_sci_rx(rx), .o_pwm_capture(capt),
		.o_pwm_fault(flt), .o_pwm_67_gated(gat), .o_xbar_in(xin),
		.o_scl_in(sclin),
		.o_ext_clk_in(ext), .o_buffered_clock_out(bco));
	pfsm_far_side pfsm_far_side_inst (.i_ref_clk(clk), .i_oe(oe),
		.i_out(po), .i_pu(pu), .i_drv(~oe), .i_val(val), .o_pad(pad));
	// ============================================================
	// Checking and closing.
	task chk(input string nm, input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task end_of_test;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 300) begin
			errors++;
			end_of_test();
		end
	end
	// ============================================================
	// Sequence.
	initial begin
		wt(2);
		chk("pullup", pu, 9'h1ff);
		rst_n = 1;
		wt(1);
		chk("oe", oe, 9'h000);
		$display("test reset done");
		src = 2'h2;
		for (int i = 0; i < 6; i++) begin
			{sel, master, single, cap, per, eoe, eout} = tbl[i];
			wt(3);
			chk("oe", oe, eoe);
			chk("out", po & eoe, eout);
			$display("test row %0d done", i);
		end
		sel = 36'h141118814;
		val[7] = 1;
		wt(3);
		chk("oe", oe, 9'h000);
		chk("select", ss, 1);
		val[7] = 0;
		wt(3);
		chk("oe", oe, 9'h004);
		chk("select", ss, 0);
		$display("test select done");
		sel = 36'h111181111;
		cap = 2'h1;
		per = 8'h03;
		val[4] = 1;
		wt(3);
		chk("fault", {flt, gat}, 9'h006);
		chk("capture", capt[0], 1);
		val[4] = 0;
		wt(3);
		chk("fault", {flt, gat}, 9'h003);
		$display("test fault done");
		sel = 36'h111111112;
		exsel = 1;
		wt(2);
		chk("ext", ext, 1);
		exsel = 0;
		wt(1);
		chk("ext", ext, 0);
		sel = 36'h111111121;
		per = 8'h50;
		for (int k = 0; k < 4; k++) begin
			src = k[1:0];
			wt(2);
			chk("clock", bco, per[4+k]);
		end
		$display("test clock done");
		master = 0;
		sel = 36'h111218144;
		val = 9'h00b;
		wt(3);
		chk("gpio in", gin, 9'h00b);
		chk("sclk in", sckin, 1);
		chk("fwd in", fwdin, 1);
		chk("rx", rx, 0);
		chk("xbar in", xin, 2'h2);
		chk("ret in", retin, 0);
		master = 1;
		sel = 36'h111111812;
		val = 9'h005;
		wt(3);
		chk("ret in", retin, 1);
		chk("xbar in", xin, 2'h1);
		chk("sclk in", sckin, 0);
		chk("scl in", sclin, 1);
		single = 1;
		sel = 36'h111121211;
		val = 9'h001;
		wt(3);
		chk("scl in", sclin, 0);
		chk("rx", rx, 0);
		single = 0;
		$display("test inputs done");
		end_of_test();
	end
endmodule
